/* dbap_pkg.sv */
// constants and types of the debug-port access layer
// Function
// - programming may start only once the programming-ready flag reads one.
// - unlocked device lets the port write memory directly.
// - locked user-row session: key, reset pulse, then poll busy flag for one.
// - user-row writes accepted only at the first 32 byte addresses.
// - buffered bytes copy into the user row one-to-one on completion.
// - busy flag clears to zero when the copy has finished.
// - in user-row mode, no read-back; only first 32 bytes writable.
// - each detected sync-character rising edge emits an event; no disable.
// - link-side logic stays clocked in every sleep mode while enabled.
// - with the processor clock stopped, no system bus access.
// - sleeping flag reads set in idle sleep or any deeper mode.
// - keep-clock bit set keeps system clock on, so bus access works.
// - keep-clock bit resets to one.
// - registers reached only through the port; two groups of offsets.
// - writing 0x59 asserts system reset; other values release it.
// - 64-bit key signatures, least significant byte first.
// - key flag reads one while active, clears when programming ends.
package dbap_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] ADDR_REV = 4'h0;
    localparam logic [3:0] ADDR_ERR = 4'h1;
    localparam logic [3:0] ADDR_CTRLP = 4'h2;
    localparam logic [3:0] ADDR_CTRLS = 4'h3;
    localparam logic [3:0] ADDR_KEYST = 4'h7;
    localparam logic [3:0] ADDR_RSTREQ = 4'h8;
    localparam logic [3:0] ADDR_CLKCTL = 4'h9;
    localparam logic [3:0] ADDR_SYSCTL = 4'ha;
    localparam logic [3:0] ADDR_SYSST = 4'hb;
    localparam logic [3:0] ADDR_CRC = 4'hc;
    // ************************************************************
    // values and field positions
    // ************************************************************
    localparam logic [7:0] RSTREQ_SIG = 8'h59;
    localparam logic [1:0] CLKCTL_RST = 2'h2;
    localparam logic [3:0] REV_DEFAULT = 4'h3; // arbitrary value
    localparam logic [63:0] KEY_NVM = 64'h4e564d50726f6720;
    localparam logic [63:0] KEY_UROW = 64'h4e564d5573267465;
    localparam int UROW_BYTES = 32;
    localparam logic [1:0] SLEEP_IDLE = 2'h1;
    localparam int KEY_UROW_BIT = 5;
    localparam int KEY_NVM_BIT = 4;
    localparam int SYS_RST_BIT = 5;
    localparam int SYS_SLEEP_BIT = 4;
    localparam int SYS_NVM_BIT = 3;
    localparam int SYS_UROW_BIT = 2;
    localparam int SYS_LOCK_BIT = 0;
    localparam int SYSCTL_COMMIT_BIT = 1;
    localparam int SYSCTL_KEEP_BIT = 0;
    localparam int CTRLS_DIS_BIT = 2;
    localparam int REV_LSB = 4;
    // ************************************************************
    // user-row session states
    // ************************************************************
    typedef enum logic [3:0] {
        UR_IDLE = 4'b0001,
        UR_OPEN = 4'b0010,
        UR_COPY = 4'b0100,
        UR_DONE = 4'b1000
    } dbap_ur_t;
endpackage

/* dbap_access_layer.sv */
// access-layer registers, key sequences, user-row buffer and sync event
module dbap_access_layer
    import dbap_pkg::*;
#(
    parameter int NBYTES = UROW_BYTES
)(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // register access from the link layer
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // key, error code and sync status from the link layer
    input wire logic i_key_valid,
    input wire logic [63:0] i_key_data,
    input wire logic [2:0] i_phy_err,
    input wire logic i_sync_active,
    // memory access requests from the link layer
    input wire logic i_acc_req,
    input wire logic i_acc_wr,
    input wire logic [15:0] i_acc_addr,
    input wire logic [7:0] i_acc_wdata,
    output logic o_acc_done,
    output logic o_acc_refused,
    output logic [7:0] o_acc_rdata,
    // system bus
    output logic o_bus_wr,
    output logic o_bus_rd,
    output logic [15:0] o_bus_addr,
    output logic [7:0] o_bus_wdata,
    input wire logic [7:0] i_bus_rdata,
    // user-row copy port
    output logic o_urow_wr,
    output logic [$clog2(NBYTES)-1:0] o_urow_addr,
    output logic [7:0] o_urow_data,
    // system side levels, asynchronous
    input wire logic i_lock_status,
    input wire logic [1:0] i_sleep_level,
    input wire logic i_cpu_clk_stopped,
    input wire logic [2:0] i_crc_status,
    input wire logic i_link_rx,
    // system control outputs
    output logic o_sys_reset,
    output logic o_keep_clock,
    output logic o_link_clk_req,
    output logic [7:0] o_ctrl_primary,
    output logic [7:0] o_ctrl_secondary,
    output logic [1:0] o_clk_sel,
    output logic o_sync_event
);
    localparam int AW = $clog2(NBYTES);

    generate
        if (NBYTES < 2 || NBYTES > 256 || (1 << AW) != NBYTES)
        begin : g_bad
            $error("NBYTES must be a power of two from 2 to 256");
        end
    endgenerate

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic rx_prev;
        logic sync_event;
        logic [7:0] ctrlp;
        logic [7:0] ctrls;
        logic link_req;
        logic [1:0] clkctl;
        logic keep_clk;
        logic [2:0] err;
        logic rst_active;
        logic key_nvm;
        logic key_urow;
        logic nvm_ready;
        dbap_ur_t ur;
        logic [AW-1:0] idx;
        logic [NBYTES-1:0][7:0] ubuf;
        logic [7:0] reg_rdata;
        logic bus_wr;
        logic bus_rd;
        logic [15:0] bus_addr;
        logic [7:0] bus_wdata;
        logic pend;
        logic pend_ref;
        logic acc_done;
        logic acc_refused;
        logic [7:0] acc_rdata;
        logic urow_wr;
        logic [AW-1:0] urow_addr;
        logic [7:0] urow_data;
    } dbap_state_t;

    dbap_state_t st_reg;
    dbap_state_t st_next;

    // synchronised view: {crc[2:0], rx, clk stopped, sleep[1:0], lock, pad}
    logic s_lock;
    logic [1:0] s_sleep;
    logic s_clkoff;
    logic s_rx;
    logic [2:0] s_crc;
    logic sleeping;
    logic busy;
    logic wr_rst;
    logic release_rst;
    logic take;
    logic [7:0] rd_mux;

    assign s_lock = st_reg.sync2[1];
    assign s_sleep = st_reg.sync2[3:2];
    assign s_clkoff = st_reg.sync2[4];
    assign s_rx = st_reg.sync2[5];
    assign s_crc = st_reg.sync2[8:6];
    assign sleeping = (s_sleep >= SLEEP_IDLE);
    assign busy = (st_reg.ur == UR_OPEN) || (st_reg.ur == UR_COPY);
    assign wr_rst = i_reg_wr && (i_reg_addr == ADDR_RSTREQ);
    assign release_rst = wr_rst && st_reg.rst_active
        && (i_reg_wdata != RSTREQ_SIG);
    assign take = i_acc_req && !st_reg.pend && !st_reg.acc_done;

    // ************************************************************
    // register read mux
    // ************************************************************
    always_comb
    begin
        rd_mux = 8'h00;
        case (i_reg_addr)
            ADDR_REV: rd_mux = {REV_DEFAULT, 4'h0};
            ADDR_ERR: rd_mux = {5'h00, st_reg.err};
            ADDR_CTRLP: rd_mux = st_reg.ctrlp;
            ADDR_CTRLS: rd_mux = st_reg.ctrls;
            ADDR_KEYST:
            begin
                rd_mux[KEY_UROW_BIT] = st_reg.key_urow;
                rd_mux[KEY_NVM_BIT] = st_reg.key_nvm;
            end
            ADDR_RSTREQ: rd_mux = {7'h00, st_reg.rst_active};
            ADDR_CLKCTL: rd_mux = {6'h00, st_reg.clkctl};
            ADDR_SYSCTL: rd_mux = {7'h00, st_reg.keep_clk};
            ADDR_SYSST:
            begin
                rd_mux[SYS_RST_BIT] = st_reg.rst_active;
                rd_mux[SYS_SLEEP_BIT] = sleeping;
                rd_mux[SYS_NVM_BIT] = st_reg.nvm_ready;
                rd_mux[SYS_UROW_BIT] = busy;
                rd_mux[SYS_LOCK_BIT] = s_lock;
            end
            ADDR_CRC: rd_mux = {5'h00, s_crc};
            default: rd_mux = 8'h00;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.sync1 = {i_crc_status, i_link_rx, i_cpu_clk_stopped,
            i_sleep_level, i_lock_status, 1'b0};
        st_next.sync2 = st_reg.sync1;
        st_next.rx_prev = s_rx;
        // event on each rising edge during sync, no disable
        st_next.sync_event = i_sync_active && s_rx && !st_reg.rx_prev;
        st_next.bus_wr = 1'b0;
        st_next.bus_rd = 1'b0;
        st_next.acc_done = 1'b0;
        st_next.urow_wr = 1'b0;
        if (i_reg_rd)
        begin
            st_next.reg_rdata = rd_mux;
        end
        // error code: a new error wins over the read clear
        if (i_phy_err != 3'h0)
        begin
            st_next.err = i_phy_err;
        end
        else if (i_reg_rd && i_reg_addr == ADDR_ERR)
        begin
            st_next.err = 3'h0;
        end
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                ADDR_CTRLP: st_next.ctrlp = i_reg_wdata;
                ADDR_CTRLS: st_next.ctrls = i_reg_wdata;
                ADDR_CLKCTL: st_next.clkctl = i_reg_wdata[1:0];
                ADDR_SYSCTL:
                    st_next.keep_clk = i_reg_wdata[SYSCTL_KEEP_BIT];
                default: st_next.ctrlp = st_next.ctrlp;
            endcase
        end
        st_next.link_req = !st_next.ctrls[CTRLS_DIS_BIT];
        if (wr_rst)
        begin
            st_next.rst_active = (i_reg_wdata == RSTREQ_SIG);
        end
        if (i_key_valid && i_key_data == KEY_NVM)
        begin
            st_next.key_nvm = 1'b1;
        end
        if (i_key_valid && i_key_data == KEY_UROW)
        begin
            st_next.key_urow = 1'b1;
        end
        // programming: first release opens, second release ends
        if (release_rst)
        begin
            if (st_reg.nvm_ready)
            begin
                st_next.nvm_ready = 1'b0;
                st_next.key_nvm = 1'b0;
            end
            else if (st_reg.key_nvm && !s_lock)
            begin
                st_next.nvm_ready = 1'b1;
            end
        end
        // ********************************************************
        // user-row session
        // ********************************************************
        case (st_reg.ur)
            UR_IDLE:
                if (release_rst && st_reg.key_urow && s_lock)
                begin
                    st_next.ur = UR_OPEN;
                    st_next.ubuf = '0;
                end
            UR_OPEN:
                if (i_reg_wr && i_reg_addr == ADDR_SYSCTL
                    && i_reg_wdata[SYSCTL_COMMIT_BIT])
                begin
                    st_next.ur = UR_COPY;
                    st_next.idx = '0;
                end
            UR_COPY:
            begin
                st_next.urow_wr = 1'b1;
                st_next.urow_addr = st_reg.idx;
                st_next.urow_data = st_reg.ubuf[st_reg.idx];
                st_next.idx = st_reg.idx + 1'b1;
                if (st_reg.idx == AW'(NBYTES - 1))
                begin
                    st_next.ur = UR_DONE;
                end
            end
            UR_DONE: st_next.ur = UR_DONE;
            default: st_next.ur = UR_IDLE;
        endcase
        if (i_reg_wr && i_reg_addr == ADDR_KEYST
            && i_reg_wdata[KEY_UROW_BIT])
        begin
            st_next.key_urow = 1'b0;
            st_next.ur = UR_IDLE;
        end
        // port disable drops every key
        if (st_reg.ctrls[CTRLS_DIS_BIT])
        begin
            st_next.key_nvm = 1'b0;
            st_next.key_urow = 1'b0;
            st_next.nvm_ready = 1'b0;
            st_next.ur = UR_IDLE;
        end
        // ********************************************************
        // memory access: take, strobe, answer
        // ********************************************************
        if (take)
        begin
            st_next.pend = 1'b1;
            st_next.pend_ref = 1'b0;
            if (st_reg.rst_active || (s_clkoff && !st_reg.keep_clk))
            begin
                st_next.pend_ref = 1'b1;
            end
            else if (st_reg.ur == UR_OPEN)
            begin
                if (i_acc_wr && i_acc_addr < 16'(NBYTES))
                begin
                    st_next.ubuf[i_acc_addr[AW-1:0]] = i_acc_wdata;
                end
                else
                begin
                    st_next.pend_ref = 1'b1;
                end
            end
            else if (st_reg.ur == UR_COPY || s_lock)
            begin
                st_next.pend_ref = 1'b1;
            end
            else
            begin
                st_next.bus_wr = i_acc_wr;
                st_next.bus_rd = !i_acc_wr;
                st_next.bus_addr = i_acc_addr;
                st_next.bus_wdata = i_acc_wdata;
            end
        end
        if (st_reg.pend)
        begin
            st_next.pend = 1'b0;
            st_next.acc_done = 1'b1;
            st_next.acc_refused = st_reg.pend_ref;
            st_next.acc_rdata = st_reg.bus_rd ? i_bus_rdata : 8'h00;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_reg <= '0;
            st_reg.ur <= UR_IDLE;
            st_reg.clkctl <= CLKCTL_RST;
            st_reg.keep_clk <= 1'b1;
            st_reg.link_req <= 1'b1;
            // link line idles high, so no false edge after reset
            st_reg.sync1[5] <= 1'b1;
            st_reg.sync2[5] <= 1'b1;
            st_reg.rx_prev <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_reg_rdata = st_reg.reg_rdata;
    assign o_acc_done = st_reg.acc_done;
    assign o_acc_refused = st_reg.acc_refused;
    assign o_acc_rdata = st_reg.acc_rdata;
    assign o_bus_wr = st_reg.bus_wr;
    assign o_bus_rd = st_reg.bus_rd;
    assign o_bus_addr = st_reg.bus_addr;
    assign o_bus_wdata = st_reg.bus_wdata;
    assign o_urow_wr = st_reg.urow_wr;
    assign o_urow_addr = st_reg.urow_addr;
    assign o_urow_data = st_reg.urow_data;
    assign o_sys_reset = st_reg.rst_active;
    assign o_keep_clock = st_reg.keep_clk;
    // link clock request stays up through sleep unless disabled
    assign o_link_clk_req = st_reg.link_req;
    assign o_ctrl_primary = st_reg.ctrlp;
    assign o_ctrl_secondary = st_reg.ctrls;
    assign o_clk_sel = st_reg.clkctl;
    assign o_sync_event = st_reg.sync_event;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    sequence s_commit;
        st_reg.ur == UR_OPEN && i_reg_wr && i_reg_addr == ADDR_SYSCTL
            && i_reg_wdata[SYSCTL_COMMIT_BIT];
    endsequence
    sequence s_copy_run;
        ##2 o_urow_wr [*8];
    endsequence

    AST_RST_SET: assert property (wr_rst && i_reg_wdata == RSTREQ_SIG
        |=> o_sys_reset) else $error("reset request not asserted");
    AST_RST_CLR: assert property (wr_rst && i_reg_wdata != RSTREQ_SIG
        |=> !o_sys_reset) else $error("reset request not released");
    AST_CLK_BLOCK: assert property (take && s_clkoff && !st_reg.keep_clk
        |=> !o_bus_wr && !o_bus_rd ##1 o_acc_done && o_acc_refused)
        else $error("bus reached with processor clock stopped");
    AST_UROW_RANGE: assert property (take && st_reg.ur == UR_OPEN
        && !st_reg.rst_active && i_acc_wr && i_acc_addr >= 16'(NBYTES)
        |-> ##2 o_acc_done && o_acc_refused)
        else $error("user-row write outside range accepted");
    AST_UROW_NOREAD: assert property (take && st_reg.ur == UR_OPEN
        && !i_acc_wr |=> !o_bus_rd ##1 o_acc_refused && o_acc_rdata == 8'h00)
        else $error("read-back allowed in user-row mode");
    AST_COPY: assert property (s_commit |-> s_copy_run)
        else $error("user-row copy did not run");
    AST_BUSY_CLR: assert property ($fell(busy) && st_reg.ur == UR_DONE
        |-> o_urow_wr && o_urow_addr == AW'(NBYTES - 1))
        else $error("busy cleared before last byte");
    AST_SLEEP: assert property (i_reg_rd && i_reg_addr == ADDR_SYSST
        && s_sleep >= SLEEP_IDLE |=> o_reg_rdata[SYS_SLEEP_BIT])
        else $error("sleeping flag missing");
    AST_EVENT: assert property (i_sync_active && $rose(s_rx)
        |=> o_sync_event) else $error("sync edge event missing");
    AST_NVM_END: assert property (release_rst && st_reg.nvm_ready
        |=> !st_reg.key_nvm && !st_reg.nvm_ready)
        else $error("programming key not cleared");
endmodule // dbap_access_layer

/* dbap_sys_model.sv */
// system bus memory model facing the access layer
module dbap_sys_model
    import dbap_pkg::*;
(
    // clock
    input wire logic i_mclk,
    // system bus from the port
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    output logic [7:0] o_bus_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    // unselected bus shows inverted last value
    assign o_bus_rdata = i_bus_rd ? mem[i_bus_addr[7:0]] : ~last_q;
    initial
    begin
        for (int k = 0; k < 256; k++)
            mem[k] = 8'(k);
    end
    always @(posedge i_mclk)
    begin
        if (i_bus_wr)
            mem[i_bus_addr[7:0]] <= i_bus_wdata;
        if (i_bus_rd)
            last_q <= mem[i_bus_addr[7:0]];
    end
endmodule // dbap_sys_model

/* dbap_access_layer_test.sv */
// self-checking bench of the access layer
module dbap_access_layer_test
    import dbap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'b0;
    logic rst_n = 1'b0;
    logic rwr = 1'b0, rrd = 1'b0, kval = 1'b0, sync = 1'b0;
    logic areq = 1'b0, awr = 1'b0, lock = 1'b0, cstop = 1'b0, rx = 1'b1;
    logic [3:0] radr = 4'h0;
    logic [7:0] rwd = 8'h00, awd = 8'h00, rdata, ardata, brd_data, bwd, udat;
    logic [63:0] key = 64'h0;
    logic [2:0] perr = 3'h0, crc = 3'h0;
    logic [15:0] aadr = 16'h0, badr;
    logic [1:0] slp = 2'h0;
    logic adone, aref, bwr, brd, uwr, sysrst, keep, sev, lclk;
    logic [4:0] uadr;
    logic [7:0] cpri, csec;
    logic [1:0] csel;
    int error_cnt = 0, cmp_count = 0, ucnt = 0, scnt = 0;

    always #25 i_mclk = ~i_mclk;

    dbap_access_layer dut (
        .i_mclk(i_mclk), .i_reset_n(rst_n),
        .i_reg_wr(rwr), .i_reg_rd(rrd), .i_reg_addr(radr),
        .i_reg_wdata(rwd), .o_reg_rdata(rdata),
        .i_key_valid(kval), .i_key_data(key), .i_phy_err(perr),
        .i_sync_active(sync),
        .i_acc_req(areq), .i_acc_wr(awr), .i_acc_addr(aadr),
        .i_acc_wdata(awd), .o_acc_done(adone), .o_acc_refused(aref),
        .o_acc_rdata(ardata),
        .o_bus_wr(bwr), .o_bus_rd(brd), .o_bus_addr(badr),
        .o_bus_wdata(bwd), .i_bus_rdata(brd_data),
        .o_urow_wr(uwr), .o_urow_addr(uadr), .o_urow_data(udat),
        .i_lock_status(lock), .i_sleep_level(slp),
        .i_cpu_clk_stopped(cstop), .i_crc_status(crc), .i_link_rx(rx),
        .o_sys_reset(sysrst), .o_keep_clock(keep),
        .o_link_clk_req(lclk), .o_ctrl_primary(cpri),
        .o_ctrl_secondary(csec), .o_clk_sel(csel), .o_sync_event(sev)
    );

    dbap_sys_model sys (
        .i_mclk(i_mclk), .i_bus_wr(bwr), .i_bus_rd(brd),
        .i_bus_addr(badr), .i_bus_wdata(bwd), .o_bus_rdata(brd_data)
    );

    // ********
    // tasks
    // ********
    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        rwr <= 1'b1;
        radr <= a;
        rwd <= d;
        @(posedge i_mclk);
        rwr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        rrd <= 1'b1;
        radr <= a;
        @(posedge i_mclk);
        rrd <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata, e);
    endtask

    // answer lands two edges after the request is raised
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic er,
                       input logic [7:0] ed);
        @(posedge i_mclk);
        areq <= 1'b1;
        awr <= w;
        aadr <= a;
        awd <= d;
        repeat (2) @(posedge i_mclk);
        areq <= 1'b0;
        #1 chk("done", {7'h0, adone}, 8'h01);
        chk("refused", {7'h0, aref}, {7'h0, er});
        chk("acc rdata", ardata, ed);
    endtask

    task automatic key_in(input logic [63:0] k);
        @(posedge i_mclk);
        kval <= 1'b1;
        key <= k;
        @(posedge i_mclk);
        kval <= 1'b0;
    endtask

    task automatic pulse;
        wr(ADDR_RSTREQ, RSTREQ_SIG);
        wr(ADDR_RSTREQ, 8'h00);
    endtask

    task automatic set_in(input logic l, input logic [1:0] s,
                          input logic c);
        @(posedge i_mclk);
        lock <= l;
        slp <= s;
        cstop <= c;
        repeat (4) @(posedge i_mclk);
    endtask

    task automatic final_report;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge i_mclk)
    begin
        if (sev === 1'b1)
            scnt++;
        if (uwr === 1'b1)
        begin
            chk("urow addr", {3'h0, uadr}, ucnt[7:0]);
            chk("urow data", udat, (ucnt == 3) ? 8'h3c : 8'h00);
            ucnt++;
        end
    end

    initial
    begin
        repeat (5000) @(posedge i_mclk);
        error_cnt++;
        final_report;
    end

    // ********
    // tests
    // ********
    initial
    begin
        repeat (5) @(posedge i_mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        chk("keep", {7'h0, keep}, 8'h01);
        chk("clk sel", {6'h0, csel}, {6'h0, CLKCTL_RST});
        rchk(ADDR_SYSCTL, 8'h01);
        rchk(ADDR_CLKCTL, {6'h0, CLKCTL_RST});
        wr(ADDR_REV, 8'hff);
        rchk(ADDR_REV, {REV_DEFAULT, 4'h0});
        rchk(4'h5, 8'h00);
        wr(ADDR_CTRLP, 8'ha5);
        rchk(ADDR_CTRLP, 8'ha5);
        chk("ctrl primary", cpri, 8'ha5);
        @(posedge i_mclk);
        perr <= 3'h2;
        crc <= 3'h5;
        @(posedge i_mclk);
        perr <= 3'h0;
        repeat (3) @(posedge i_mclk);
        rchk(ADDR_ERR, 8'h02);
        rchk(ADDR_ERR, 8'h00);
        rchk(ADDR_CRC, 8'h05);
        wr(ADDR_RSTREQ, 8'h58);
        rchk(ADDR_RSTREQ, 8'h00);
        wr(ADDR_RSTREQ, RSTREQ_SIG);
        rchk(ADDR_RSTREQ, 8'h01);
        chk("sys reset", {7'h0, sysrst}, 8'h01);
        rchk(ADDR_SYSST, 8'h20);
        acc(1'b0, 16'h0010, 8'h00, 1'b1, 8'h00);
        wr(ADDR_RSTREQ, 8'h00);
        rchk(ADDR_RSTREQ, 8'h00);
        acc(1'b1, 16'h0040, 8'h5a, 1'b0, 8'h00);
        acc(1'b0, 16'h0040, 8'h00, 1'b0, 8'h5a);
        key_in(KEY_NVM ^ 64'h1);
        rchk(ADDR_KEYST, 8'h00);
        key_in(KEY_NVM);
        rchk(ADDR_KEYST, 8'h10);
        rchk(ADDR_SYSST, 8'h00);
        pulse;
        rchk(ADDR_SYSST, 8'h08);
        acc(1'b1, 16'h0041, 8'h3c, 1'b0, 8'h00);
        pulse;
        rchk(ADDR_KEYST, 8'h00);
        rchk(ADDR_SYSST, 8'h00);
        set_in(1'b1, 2'h0, 1'b0);
        acc(1'b1, 16'h0002, 8'h11, 1'b1, 8'h00);
        key_in(KEY_UROW);
        rchk(ADDR_KEYST, 8'h20);
        pulse;
        rchk(ADDR_SYSST, 8'h05);
        acc(1'b1, 16'h0003, 8'h3c, 1'b0, 8'h00);
        acc(1'b1, 16'h0020, 8'h77, 1'b1, 8'h00);
        acc(1'b0, 16'h0003, 8'h00, 1'b1, 8'h00);
        wr(ADDR_SYSCTL, 8'h03);
        repeat (40) @(posedge i_mclk);
        chk("urow count", ucnt[7:0], 8'h20);
        rchk(ADDR_SYSST, 8'h01);
        wr(ADDR_KEYST, 8'h20);
        rchk(ADDR_KEYST, 8'h00);
        pulse;
        set_in(1'b0, 2'h0, 1'b0);
        sync <= 1'b1;
        repeat (3)
        begin
            rx <= 1'b0;
            repeat (4) @(posedge i_mclk);
            rx <= 1'b1;
            repeat (4) @(posedge i_mclk);
        end
        repeat (4) @(posedge i_mclk);
        sync <= 1'b0;
        chk("sync events", scnt[7:0], 8'h03);
        set_in(1'b0, SLEEP_IDLE, 1'b0);
        rchk(ADDR_SYSST, 8'h10);
        set_in(1'b0, 2'h3, 1'b1);
        rchk(ADDR_SYSST, 8'h10);
        chk("link clk req", {7'h0, lclk}, 8'h01);
        acc(1'b0, 16'h0040, 8'h00, 1'b0, 8'h5a);
        wr(ADDR_SYSCTL, 8'h00);
        #1 chk("keep", {7'h0, keep}, 8'h00);
        acc(1'b0, 16'h0040, 8'h00, 1'b1, 8'h00);
        key_in(KEY_NVM);
        rchk(ADDR_KEYST, 8'h10);
        wr(ADDR_CTRLS, 8'h04);
        #1 chk("link clk req", {7'h0, lclk}, 8'h00);
        chk("ctrl secondary", csec, 8'h04);
        rchk(ADDR_KEYST, 8'h00);
        wr(ADDR_CTRLS, 8'h00);
        #1 chk("link clk req", {7'h0, lclk}, 8'h01);
        final_report;
    end
endmodule // dbap_access_layer_test
